// ---- design/mmc_pkg.sv ----
package mmc_pkg;
  localparam int unsigned MMC_CLK_HZ = 100_000_000;
  localparam int unsigned MMC_CYC_PER_US = MMC_CLK_HZ / 1_000_000;
  localparam int unsigned MMC_CYC_PER_MS = MMC_CLK_HZ / 1_000;
  // longest times, in their own unit
  localparam int unsigned MMC_INIT_TIME_MS = 2000;
  localparam int unsigned MMC_RESUME_TIME_MS = 300;
  // least reset pulse, in microseconds
  localparam int unsigned MMC_RST_PULSE_US = 2;
  localparam int unsigned MMC_INIT_CYC = MMC_INIT_TIME_MS * MMC_CYC_PER_MS;
  localparam int unsigned MMC_RESUME_CYC = MMC_RESUME_TIME_MS * MMC_CYC_PER_MS;
  localparam int unsigned MMC_RST_MIN_CYC = MMC_RST_PULSE_US * MMC_CYC_PER_US;
  localparam int MMC_TMR_W = 32;
  localparam int MMC_RST_W = 9;

  // register byte offsets
  localparam logic [7:0] MMC_STATUS_OFS = 8'h00;
  localparam logic [7:0] MMC_FLAGS_OFS = 8'h04;
  localparam logic [7:0] MMC_MASK_OFS = 8'h08;
  localparam logic [7:0] MMC_CTRL_OFS = 8'h0C;
  localparam logic [7:0] MMC_STOPS_OFS = 8'h10;

  // status fields
  localparam int MMC_ST_NOT_READY = 0;
  localparam int MMC_ST_LOW_POWER = 1;
  localparam int MMC_ST_SELECTED = 2;
  localparam int MMC_ST_STATE_LO = 4;
  // flag and mask fields
  localparam int MMC_FLAG_W = 9;
  localparam int MMC_FL_READY = 0;
  localparam int MMC_FL_LOS_LO = 1;
  localparam int MMC_FL_FAULT_LO = 5;
  localparam int MMC_LANES = 4;
  // control fields
  localparam int MMC_CTRL_PDOWN = 0;

  localparam logic [MMC_FLAG_W-1:0] MMC_MASK_RST = 9'h000;
  localparam logic [MMC_FLAG_W-1:0] MMC_FLAG_RST = 9'h000;

  typedef enum logic [1:0] {
    MMC_INIT = 2'b00,
    MMC_READY = 2'b01,
    MMC_LOWPWR = 2'b10,
    MMC_RESUME = 2'b11
  } mmc_state_type;
endpackage : mmc_pkg

// ---- design/mmc_ctrl.sv ----
// What this block does
// RULE_01: fully functional within 2000 ms of start
// RULE_02: reset pin low over 2 us resets
// RULE_03: serial bus answers within 2000 ms
// RULE_04: clear not-ready bit, raise interrupt after init
// RULE_05: functional within 2000 ms after reset release
// RULE_06: low-power pin high enters low power quickly
// RULE_07: interrupt low within 200 ms of event
// RULE_08: flags clear on read, interrupt releases
// RULE_09: read-clear timing from end of read
// RULE_10: loss of signal sets flag and interrupt
// RULE_11: any condition sets flag and interrupt
// RULE_12: mask set inhibits interrupt within 100 ms
// RULE_13: mask clear restores interrupt within 100 ms
// RULE_14: select asserted enables serial bus answers
// RULE_15: select released stops serial bus answers
// RULE_16: power-down bit set enters low power
// RULE_17: power-down bit cleared, functional within 300 ms
// RULE_18: readiness shown by interrupt from not-ready clear
// RULE_19: mask and power-down timing from write end
// RULE_20: host reads flags after interrupt
// RULE_21: interrupt holds while unmasked flag set
// RULE_22: low power on pin or power-down bit
//
// The implementer's own choices: register access over APB and the placing of the registers.
module mmc_ctrl
  import mmc_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = MMC_INIT_CYC,
  parameter int unsigned RESUME_CYCLES = MMC_RESUME_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic module_reset_n,
  input wire logic module_select_n,
  input wire logic low_power_pin,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [MMC_LANES-1:0] rx_los_in,
  input wire logic [MMC_LANES-1:0] tx_fault_in,
  output logic attention_out_n,
  output logic module_present_n,
  output logic low_power_out,
  output logic serial_answer_en
);

  // two-stage synchronisers for every pin input; the APB inputs and presetn are used as they come
  logic [1:0] rst_s_r;
  logic [1:0] sel_s_r;
  logic [1:0] lpp_s_r;
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic [MMC_LANES-1:0] los_a_r;
  logic [MMC_LANES-1:0] los_b_r;
  logic [MMC_LANES-1:0] flt_a_r;
  logic [MMC_LANES-1:0] flt_b_r;

  // control pins start at their idle levels, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_s_r <= 2'h3;
      sel_s_r <= 2'h3;
      lpp_s_r <= 2'h0;
    end else begin
      rst_s_r <= {rst_s_r[0], module_reset_n};
      sel_s_r <= {sel_s_r[0], module_select_n};
      lpp_s_r <= {lpp_s_r[0], low_power_pin};
    end
  end

  // 2-wire bus lines idle high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
    end
  end

  // per-lane conditions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      los_a_r <= '0;
      los_b_r <= '0;
      flt_a_r <= '0;
      flt_b_r <= '0;
    end else begin
      los_a_r <= rx_los_in;
      los_b_r <= los_a_r;
      flt_a_r <= tx_fault_in;
      flt_b_r <= flt_a_r;
    end
  end

  logic rst_pin_n;
  logic sel_n;
  logic lp_pin;
  assign rst_pin_n = rst_s_r[1];
  assign sel_n = sel_s_r[1];
  assign lp_pin = lpp_s_r[1];

  // reset pin filter: short low pulses are ignored
  logic [MMC_RST_W-1:0] rst_cnt_r;
  logic soft_rst_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_r <= '0;
      soft_rst_r <= 1'b0;
    end else if (rst_pin_n) begin
      rst_cnt_r <= '0;
      soft_rst_r <= 1'b0;
    end else if (rst_cnt_r < MMC_RST_W'(MMC_RST_MIN_CYC - 1)) begin
      rst_cnt_r <= rst_cnt_r + 1'b1;
    end else begin
      // RULE_02 pulse length met
      soft_rst_r <= 1'b1;
    end
  end

  // 2-wire bus: stop condition, then the next falling clock marks the end
  logic scl_d_r;
  logic sda_d_r;
  logic stop_seen_r;
  logic [15:0] stops_r;
  logic stop_cond;
  logic scl_fall;
  assign stop_cond = scl_s_r[1] && scl_d_r && sda_s_r[1] && !sda_d_r;
  assign scl_fall = scl_d_r && !scl_s_r[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  // a stop waits for the next falling clock before it counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_seen_r <= 1'b0;
    end else if (stop_cond) begin
      stop_seen_r <= 1'b1;
    end else if (scl_fall) begin
      stop_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stops_r <= '0;
    end else if (scl_fall && stop_seen_r) begin
      stops_r <= stops_r + 1'b1;
    end
  end

  // control registers
  logic pdown_r;
  logic [MMC_FLAG_W-1:0] mask_r;
  logic [MMC_FLAG_W-1:0] flags_r;
  mmc_state_type state_r;
  logic [MMC_TMR_W-1:0] tmr_r;
  logic lp_req;
  logic init_done;
  logic resume_done;
  logic acc;
  logic wr_acc;
  logic rd_flags;

  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign rd_flags = acc && !pwrite && (paddr == MMC_FLAGS_OFS);
  // RULE_22 either source requests low power
  assign lp_req = lp_pin || pdown_r;
  assign init_done = (state_r == MMC_INIT) && (tmr_r >= MMC_TMR_W'(INIT_CYCLES - 1));
  assign resume_done = (state_r == MMC_RESUME) && (tmr_r >= MMC_TMR_W'(RESUME_CYCLES - 1));

  // RULE_19 writes act at the completing access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdown_r <= 1'b0;
      mask_r <= MMC_MASK_RST;
    end else if (soft_rst_r) begin
      pdown_r <= 1'b0;
      mask_r <= MMC_MASK_RST;
    end else if (wr_acc) begin
      // RULE_12 mask write
      if (paddr == MMC_MASK_OFS) begin
        mask_r <= pwdata[MMC_FLAG_W-1:0];
      end
      // RULE_16 power-down write
      if (paddr == MMC_CTRL_OFS) begin
        pdown_r <= pwdata[MMC_CTRL_PDOWN];
      end
    end
  end

  // power and readiness sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= MMC_INIT;
      tmr_r <= '0;
    end else if (soft_rst_r) begin
      // RULE_05 held in init until the pin rises
      state_r <= MMC_INIT;
      tmr_r <= '0;
    end else begin
      case (state_r)
        MMC_INIT: begin
          tmr_r <= tmr_r + 1'b1;
          // RULE_01 init time bound
          if (init_done) begin
            state_r <= MMC_READY;
            tmr_r <= '0;
          end
        end
        MMC_READY: begin
          // RULE_06 pin request acts at once
          if (lp_req) begin
            state_r <= MMC_LOWPWR;
          end
        end
        MMC_LOWPWR: begin
          tmr_r <= '0;
          if (!lp_req) begin
            state_r <= MMC_RESUME;
          end
        end
        MMC_RESUME: begin
          tmr_r <= tmr_r + 1'b1;
          if (lp_req) begin
            state_r <= MMC_LOWPWR;
            tmr_r <= '0;
          // RULE_17 resume time bound
          end else if (resume_done) begin
            state_r <= MMC_READY;
            tmr_r <= '0;
          end
        end
        default: begin
          state_r <= MMC_INIT;
          tmr_r <= '0;
        end
      endcase
    end
  end

  // flags: set beats a clear in the same cycle
  logic [MMC_FLAG_W-1:0] flag_set;
  logic [MMC_FLAG_W-1:0] flags_nxt;

  always_comb begin
    flag_set = '0;
    // RULE_04 readiness raises its own flag
    // RULE_18 readiness shown through the interrupt
    flag_set[MMC_FL_READY] = init_done || (resume_done && !lp_req);
    // RULE_10 loss of signal per lane
    flag_set[MMC_FL_LOS_LO +: MMC_LANES] = los_b_r;
    // RULE_11 transmit fault per lane
    flag_set[MMC_FL_FAULT_LO +: MMC_LANES] = flt_b_r;
    flags_nxt = flags_r;
    // RULE_08 clear on read
    // RULE_09 cleared at the completing read
    if (rd_flags) begin
      // only the bits the host was shown are cleared, a later one survives
      flags_nxt = flags_r & ~prdata[MMC_FLAG_W-1:0];
    end
    flags_nxt = flags_nxt | flag_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= MMC_FLAG_RST;
    end else if (soft_rst_r) begin
      flags_r <= MMC_FLAG_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // pin outputs, each from its own flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attention_out_n <= 1'b1;
    end else begin
      // RULE_07 interrupt follows flags
      // RULE_13 unmasked flags drive the pin
      // RULE_21 held while any unmasked flag set
      attention_out_n <= ~|(flags_r & ~mask_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_present_n <= 1'b0;
    end else begin
      module_present_n <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_out <= 1'b0;
    end else begin
      // RULE_06 pin request lowers power even during init
      low_power_out <= !soft_rst_r && ((state_r == MMC_LOWPWR) || lp_req);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_answer_en <= 1'b0;
    end else begin
      // RULE_03 answers once initialisation ends
      // RULE_14 select enables answers
      // RULE_15 deselect stops answers
      serial_answer_en <= !sel_n && !soft_rst_r && (state_r != MMC_INIT);
    end
  end

  // APB slave: one wait-free access phase, data registered in setup
  function automatic logic mmc_mapped(input logic [7:0] a);
    mmc_mapped = (a == MMC_STATUS_OFS) || (a == MMC_FLAGS_OFS) || (a == MMC_MASK_OFS) ||
      (a == MMC_CTRL_OFS) || (a == MMC_STOPS_OFS);
  endfunction : mmc_mapped

  logic [31:0] rd_val;

  always_comb begin
    rd_val = '0;
    case (paddr)
      MMC_STATUS_OFS: begin
        rd_val[MMC_ST_NOT_READY] = (state_r != MMC_READY);
        rd_val[MMC_ST_LOW_POWER] = (state_r == MMC_LOWPWR);
        rd_val[MMC_ST_SELECTED] = !sel_n;
        rd_val[MMC_ST_STATE_LO +: 2] = state_r;
      end
      MMC_FLAGS_OFS: rd_val[MMC_FLAG_W-1:0] = flags_r;
      MMC_MASK_OFS: rd_val[MMC_FLAG_W-1:0] = mask_r;
      MMC_CTRL_OFS: rd_val[MMC_CTRL_PDOWN] = pdown_r;
      MMC_STOPS_OFS: rd_val[15:0] = stops_r;
      default: rd_val = '0;
    endcase
  end

  logic setup_cyc;
  assign setup_cyc = psel && !penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_cyc;
      pslverr <= setup_cyc && !mmc_mapped(paddr);
    end
  end

  // read data stands only in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_cyc && !pwrite) begin
      prdata <= rd_val;
    end else begin
      prdata <= '0;
    end
  end

endmodule : mmc_ctrl

// ---- testbench/mmc_ctrl_properties.sv ----
module mmc_ctrl_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic module_reset_n,
  input wire logic module_select_n,
  input wire logic low_power_pin,
  input wire logic attention_out_n,
  input wire logic module_present_n,
  input wire logic low_power_out,
  input wire logic serial_answer_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [8:0] low_cnt_r;
  wire acc = psel && penable && pready;
  wire wr_acc = acc && pwrite;
  // cycles the reset pin has stayed low, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt_r <= 9'h000;
    else if (module_reset_n) low_cnt_r <= 9'h000;
    else if (!low_cnt_r[8]) low_cnt_r <= low_cnt_r + 9'h001;
  end
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    acc;
  endsequence
  rdy_after_setup_a: assert property (apb_setup |=> apb_access)
    else $error("no pready after setup");
  rdy_in_access_a: assert property (pready |-> acc && $past(psel && !penable))
    else $error("pready outside access");
  err_with_rdy_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  present_low_a: assert property (!module_present_n)
    else $error("module not present");
  sel_off_a: assert property (module_select_n [*5] |-> !serial_answer_en)
    else $error("answering while deselected");
  soft_rst_a: assert property (
    low_cnt_r > 9'h0DC |-> attention_out_n && !low_power_out && !serial_answer_en)
    else $error("soft reset not applied");
  att_rel_a: assert property ($rose(attention_out_n) |->
    $past(acc, 2) || $past(acc, 3) || !module_reset_n)
    else $error("interrupt released without cause");
  lp_cause_a: assert property ($rose(low_power_out) |->
    low_power_pin || $past(wr_acc, 2) || $past(wr_acc, 3))
    else $error("low power without request");
endmodule : mmc_ctrl_properties

// ---- testbench/mmc_host_model.sv ----
module mmc_host_model (
  input wire logic pclk,
  output logic module_reset_n,
  output logic module_select_n,
  output logic low_power_pin,
  output logic scl_in,
  output logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {module_reset_n, module_select_n, low_power_pin, scl_in, sda_in} = 5'h1B;
  end
  task automatic pins(input logic sel_n, input logic lp);
    module_select_n <= sel_n;
    low_power_pin <= lp;
  endtask : pins
  // reset held for the asked cycles
  task automatic hold_reset(input int n);
    module_reset_n <= 1'h0;
    repeat (n) @(posedge pclk);
    module_reset_n <= 1'h1;
  endtask : hold_reset
  // frame ends with stop, then one clock fall
  task automatic frame(input logic [7:0] b);
    logic [1:0] q[$];
    q = {2'h2};
    for (int i = 7; i >= 0; i--) q = {q, {1'h0, b[i]}, {1'h1, b[i]}};
    q = {q, 2'h1, 2'h3, 2'h0, 2'h2, 2'h3, 2'h1, 2'h3};
    foreach (q[i]) begin
      // clock moves first, data half a phase later, so data never races it
      scl_in <= q[i][1];
      repeat (4) @(posedge pclk);
      sda_in <= q[i][0];
      repeat (4) @(posedge pclk);
    end
  endtask : frame
endmodule : mmc_host_model

// ---- testbench/mmc_ctrl_tb.sv ----
module mmc_ctrl_tb
  import mmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned INIT_N = 50;
  localparam int unsigned RES_N = 20;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic [3:0] rx_los_in = 4'h0, tx_fault_in = 4'h0;
  logic pready, pslverr, perr, attention_out_n, module_present_n, low_power_out;
  logic serial_answer_en, module_reset_n, module_select_n, low_power_pin, scl_in, sda_in;
  int fail_count = 0, checks_done = 0, seed = 85477, v;
  wire [2:0] obs = {attention_out_n, low_power_out, serial_answer_en};
  mmc_ctrl #(.INIT_CYCLES(INIT_N), .RESUME_CYCLES(RES_N)) uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .module_reset_n(module_reset_n),
    .module_select_n(module_select_n),
    .low_power_pin(low_power_pin),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .rx_los_in(rx_los_in),
    .tx_fault_in(tx_fault_in),
    .attention_out_n(attention_out_n),
    .module_present_n(module_present_n),
    .low_power_out(low_power_out),
    .serial_answer_en(serial_answer_en)
  );
  mmc_host_model host (
    .pclk(pclk),
    .module_reset_n(module_reset_n),
    .module_select_n(module_select_n),
    .low_power_pin(low_power_pin),
    .scl_in(scl_in),
    .sda_in(sda_in)
  );
  initial begin
    forever #5 pclk = ~pclk;
  end
  initial begin
    #50000;
    fail_count++;
    end_of_test();
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rdata = prdata;
    perr = pslverr;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdata, e);
  endtask : rd
  task automatic idle(input int n);
    psel <= 1'h0;
    penable <= 1'h0;
    repeat (n) @(posedge pclk);
  endtask : idle
  task automatic wt(input int k, input logic val, input int lim);
    int n;
    n = 0;
    idle(0);
    do begin
      @(posedge pclk);
      n++;
    end while (obs[k] !== val && n < lim);
    chk(obs[k], val);
  endtask : wt
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd(MMC_STATUS_OFS, 32'h1);
    chk(module_present_n, 1'h0);
    wt(2, 1'h0, INIT_N + 10);
    rd(MMC_STATUS_OFS, 32'h10);
    rd(MMC_FLAGS_OFS, 32'h1);
    wt(2, 1'h1, 10);
    for (int i = 0; i < 8; i++) begin
      v = 1 + ($unsigned($random(seed)) % 15);
      if (i[0]) tx_fault_in <= v[3:0];
      else rx_los_in <= v[3:0];
      wt(2, 1'h0, 10);
      rx_los_in <= 4'h0;
      tx_fault_in <= 4'h0;
      idle(4);
      rd(MMC_FLAGS_OFS, i[0] ? v << 5 : v << 1);
      rd(MMC_FLAGS_OFS, 32'h0);
      wt(2, 1'h1, 10);
    end
    tx_fault_in <= 4'h2;
    wt(2, 1'h0, 10);
    rd(MMC_FLAGS_OFS, 32'h40);
    idle(4);
    chk(attention_out_n, 1'h0);
    tx_fault_in <= 4'h0;
    idle(4);
    rd(MMC_FLAGS_OFS, 32'h40);
    wt(2, 1'h1, 10);
    v = $random(seed);
    apb(1'h1, MMC_MASK_OFS, v);
    rd(MMC_MASK_OFS, v & 32'h1FF);
    apb(1'h1, MMC_MASK_OFS, 32'h1FF);
    rx_los_in <= 4'h8;
    idle(8);
    chk(attention_out_n, 1'h1);
    apb(1'h1, MMC_MASK_OFS, 32'h0);
    wt(2, 1'h0, 10);
    rx_los_in <= 4'h0;
    idle(4);
    rd(MMC_FLAGS_OFS, 32'h10);
    rd(8'h14, 32'h0);
    chk(perr, 1'h1);
    host.pins(1'h0, 1'h0);
    wt(0, 1'h1, 10);
    host.frame(v[7:0]);
    rd(MMC_STOPS_OFS, 32'h1);
    host.pins(1'h1, 1'h0);
    wt(0, 1'h0, 10);
    host.pins(1'h1, 1'h1);
    wt(1, 1'h1, 10);
    host.pins(1'h1, 1'h0);
    wt(2, 1'h0, RES_N + 10);
    rd(MMC_FLAGS_OFS, 32'h1);
    apb(1'h1, MMC_CTRL_OFS, 32'h1);
    rd(MMC_CTRL_OFS, 32'h1);
    wt(1, 1'h1, 10);
    rd(MMC_STATUS_OFS, 32'h23);
    apb(1'h1, MMC_CTRL_OFS, 32'h0);
    wt(1, 1'h0, 10);
    wt(2, 1'h0, RES_N + 10);
    rd(MMC_FLAGS_OFS, 32'h1);
    idle(1);
    host.hold_reset(50);
    rd(MMC_STATUS_OFS, 32'h10);
    idle(1);
    host.hold_reset(250);
    rd(MMC_STATUS_OFS, 32'h1);
    wt(2, 1'h0, INIT_N + 10);
    rd(MMC_FLAGS_OFS, 32'h1);
    end_of_test();
  end
endmodule : mmc_ctrl_tb
bind mmc_ctrl mmc_ctrl_properties chk_i (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .pslverr(pslverr),
  .module_reset_n(module_reset_n),
  .module_select_n(module_select_n),
  .low_power_pin(low_power_pin),
  .attention_out_n(attention_out_n),
  .module_present_n(module_present_n),
  .low_power_out(low_power_out),
  .serial_answer_en(serial_answer_en)
);
